// ### hdl/qcpr_top.sv
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RL1 - Report committed receive bytes, thirteen bits.
// RL2 - Receive queue holds 4096 bytes total.
// RL3 - Count rises only at packet completion; a release lowers it.
// RL4 - Completed packet raises interrupt when enabled.
// RL5 - Full receive queue discards incoming frame.
// RL6 - Enqueue bit queues prepared transmit frame.
// RL7 - Enqueue bit reads one until sent.
// RL8 - Host waits enqueue bit low first.
// RL9 - Release bit frees current receive frame; the code frees only the bytes read since the last release.
// RL10 - Release bit reads one until freed.
// RL11 - Host waits release bit low first.
// RL12 - Transmit pointer, eleven bits, resets zero.
// RL13 - Auto advance by access size.
// RL14 - Without auto advance, only writes move.
// RL15 - Pointer reloads after frame is enqueued.
// RL16 - Data writes fill transmit, reads drain receive.
// RL17 - Auto advance wraps modulo eleven bits.
module qcpr_top (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_last_i,
  output logic rx_ready_o,
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  output logic tx_last_o,
  input wire logic tx_ready_i,
  output logic irq_o
);

  typedef enum logic [0:0] {TX_IDLE, TX_SEND} qcpr_tx_state_type;
  typedef enum logic [1:0] {RX_DATA, RX_STAT, RX_DROP} qcpr_rx_state_type;

  // ---------------------------------------------------------------
  // Storage.
  // ---------------------------------------------------------------
  logic [7:0] tx_mem [0:qcpr_pkg::TXQ_DEPTH-1];
  logic [7:0] rx_mem [0:qcpr_pkg::RXQ_DEPTH-1];

  // ---------------------------------------------------------------
  // Bus slave.
  // ---------------------------------------------------------------
  // Writes take one wait state so that a read right behind a write
  // always sees the updated register.
  logic wr_pend;
  logic [5:0] w_idx;
  logic [1:0] w_lane;
  logic [2:0] w_nbytes;

  wire logic addr_take = hsel_i & htrans_i[1] & hready_i;
  wire logic rd_take = addr_take & ~hwrite_i;
  wire logic wr_take = addr_take & hwrite_i;
  wire logic [5:0] a_idx = haddr_i[7:2];
  wire logic [1:0] a_lane = haddr_i[1:0];
  wire logic [2:0] a_nbytes = (hsize_i == qcpr_pkg::HSIZE_BYTE) ? 3'h1 :
                              (hsize_i == qcpr_pkg::HSIZE_HALF) ? 3'h2 : 3'h4;
  wire logic w_en = wr_pend;
  wire logic [15:0] w_reg = hwdata_i[15:0];
  wire logic w_data = w_en & (w_idx == qcpr_pkg::IDX_QUEUE_DATA);
  wire logic w_enq = w_en & (w_idx == qcpr_pkg::IDX_TX_ENQUEUE_COMMAND);
  wire logic w_rel = w_en & (w_idx == qcpr_pkg::IDX_RX_RELEASE_COMMAND);
  wire logic w_ptr = w_en & (w_idx == qcpr_pkg::IDX_TX_FRAME_POINTER);
  wire logic w_stat = w_en & (w_idx == qcpr_pkg::IDX_INT_STATUS);
  wire logic w_mask = w_en & (w_idx == qcpr_pkg::IDX_INT_MASK);
  wire logic r_data = rd_take & (a_idx == qcpr_pkg::IDX_QUEUE_DATA);

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      wr_pend <= 1'b0;
      hreadyout_o <= 1'b1;
      w_idx <= 6'h00;
      w_lane <= 2'h0;
      w_nbytes <= 3'h0;
    end else begin
      wr_pend <= wr_take;
      hreadyout_o <= ~wr_take;
      if (wr_take) begin
        w_idx <= a_idx;
        w_lane <= a_lane;
        w_nbytes <= a_nbytes;
      end
    end
  end

  // ---------------------------------------------------------------
  // Byte lanes of the queue data register.
  // ---------------------------------------------------------------
  logic [11:0] rx_rd;
  logic [7:0] rd_lane [0:3];
  logic [7:0] wbyte [0:3];

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : lane_gen
      wire logic [1:0] rk = 2'(g) - a_lane;
      wire logic [1:0] wl = w_lane + 2'(g);
      // RL16 - receive queue read.
      assign rd_lane[g] = ({1'b0, rk} < a_nbytes) ? rx_mem[rx_rd + {10'h000, rk}] : 8'h00;
      assign wbyte[g] = hwdata_i[{wl, 3'h0} +: 8];
    end
  endgenerate

  // ---------------------------------------------------------------
  // Transmit pointer and enqueue.
  // ---------------------------------------------------------------
  qcpr_tx_state_type tx_state;
  logic [10:0] tx_ptr;
  logic tx_auto;
  logic [10:0] tx_base;
  logic [10:0] tx_rd;
  logic [10:0] tx_end;

  wire logic tx_busy = (tx_state == TX_SEND);
  wire logic tx_more = (tx_rd != tx_end);
  wire logic tx_move = tx_busy & tx_more & (~tx_valid_o | tx_ready_i);
  wire logic tx_done = tx_busy & ((tx_valid_o & tx_ready_i & tx_last_o) | (~tx_valid_o & ~tx_more));
  wire logic enq_start = w_enq & w_reg[qcpr_pkg::ENQUEUE_FRAME_BIT] & ~tx_busy;

  // RL16 - transmit queue write.
  always_ff @(posedge clk_sys_i) begin
    for (int j = 0; j < 4; j++) begin
      if (w_data && (3'(j) < w_nbytes)) begin
        tx_mem[tx_ptr + 11'(j)] <= wbyte[j];
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      // RL12 - pointer reset value.
      tx_ptr <= qcpr_pkg::TX_PTR_RESET;
      tx_auto <= 1'b0;
      tx_base <= qcpr_pkg::TX_PTR_RESET;
    end else if (tx_done) begin
      // RL15 - reload at next location.
      tx_ptr <= tx_end;
      tx_base <= tx_end;
    end else if (w_ptr) begin
      // RL14 - host write moves pointer.
      tx_ptr <= w_reg[qcpr_pkg::TX_PTR_W-1:0];
      tx_auto <= w_reg[qcpr_pkg::TX_POINTER_AUTO_ADVANCE];
    end else if (w_data && tx_auto) begin
      // RL13 - advance by size.
      // RL17 - wraps by field width.
      tx_ptr <= tx_ptr + {8'h00, w_nbytes};
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      tx_state <= TX_IDLE;
      tx_rd <= qcpr_pkg::TX_PTR_RESET;
      tx_end <= qcpr_pkg::TX_PTR_RESET;
      tx_valid_o <= 1'b0;
      tx_data_o <= 8'h00;
      tx_last_o <= 1'b0;
    end else begin
      case (tx_state)
        TX_IDLE: begin
          // RL6 - enqueue prepared frame.
          if (enq_start) begin
            tx_state <= TX_SEND;
            tx_rd <= tx_base;
            tx_end <= tx_ptr;
          end
        end
        TX_SEND: begin
          if (tx_move) begin
            tx_valid_o <= 1'b1;
            tx_data_o <= tx_mem[tx_rd];
            tx_last_o <= ((tx_rd + 11'h001) == tx_end);
            tx_rd <= tx_rd + 11'h001;
          end else if (tx_ready_i) begin
            tx_valid_o <= 1'b0;
            tx_last_o <= 1'b0;
          end
          // RL7 - busy until sent.
          if (tx_done) begin
            tx_state <= TX_IDLE;
          end
        end
        default: begin
          tx_state <= TX_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Receive queue.
  // ---------------------------------------------------------------
  qcpr_rx_state_type rx_state;
  qcpr_rx_state_type next_rx_state;
  logic [11:0] rx_head;
  logic [11:0] rx_wr;
  logic [12:0] rx_fill;
  logic [12:0] rx_frame_len;
  logic [1:0] stat_cnt;
  logic rel_busy;
  logic [7:0] stat_byte;

  // RL2 - capacity includes status word.
  wire logic [12:0] rx_free = qcpr_pkg::RXQ_BYTES - rx_fill - rx_frame_len;
  wire logic rx_room = (rx_free > qcpr_pkg::RX_STATUS_BYTES);
  wire logic rx_take = rx_valid_i & rx_ready_o;
  wire logic rx_keep = (rx_state == RX_DATA) & rx_take & rx_room;
  wire logic rx_drop = (rx_state == RX_DATA) & rx_take & ~rx_room;
  wire logic stat_wr = (rx_state == RX_STAT);
  wire logic stat_done = stat_wr & (stat_cnt == qcpr_pkg::RX_STATUS_LAST);
  wire logic rel_start = w_rel & w_reg[qcpr_pkg::RELEASE_FRAME_BIT] & ~rel_busy;
  wire logic [12:0] commit_amt = stat_done ? (rx_frame_len + qcpr_pkg::RX_STATUS_BYTES) : 13'h0000;
  wire logic [12:0] rel_amt = rel_busy ? {1'b0, rx_rd - rx_head} : 13'h0000;

  always_comb begin
    case (stat_cnt)
      2'h0: stat_byte = rx_frame_len[7:0];
      2'h1: stat_byte = {3'h0, rx_frame_len[12:8]};
      default: stat_byte = 8'h00;
    endcase
  end

  always_comb begin
    next_rx_state = rx_state;
    case (rx_state)
      RX_DATA: begin
        if (rx_keep && rx_last_i) begin
          next_rx_state = RX_STAT;
        end else if (rx_drop && !rx_last_i) begin
          next_rx_state = RX_DROP;
        end
      end
      RX_STAT: begin
        if (stat_done) begin
          next_rx_state = RX_DATA;
        end
      end
      RX_DROP: begin
        if (rx_take && rx_last_i) begin
          next_rx_state = RX_DATA;
        end
      end
      default: begin
        next_rx_state = RX_DATA;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (rx_keep) begin
      rx_mem[rx_wr] <= rx_data_i;
    end else if (stat_wr) begin
      rx_mem[rx_wr] <= stat_byte;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rx_state <= RX_DATA;
      rx_ready_o <= 1'b0;
      rx_wr <= 12'h000;
      rx_frame_len <= 13'h0000;
      stat_cnt <= 2'h0;
    end else begin
      rx_state <= next_rx_state;
      // The status word is written while the source is held off.
      rx_ready_o <= (next_rx_state != RX_STAT);
      if (rx_keep) begin
        rx_wr <= rx_wr + 12'h001;
        rx_frame_len <= rx_frame_len + 13'h0001;
      end else if (rx_drop) begin
        // RL5 - discard whole frame.
        rx_wr <= rx_wr - rx_frame_len[11:0];
        rx_frame_len <= 13'h0000;
      end else if (stat_wr) begin
        rx_wr <= rx_wr + 12'h001;
        stat_cnt <= stat_cnt + 2'h1;
        if (stat_done) begin
          rx_frame_len <= 13'h0000;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rx_fill <= 13'h0000;
      rx_head <= 12'h000;
      rx_rd <= 12'h000;
      rel_busy <= 1'b0;
    end else begin
      // RL3 - count moves at completion.
      rx_fill <= rx_fill + commit_amt - rel_amt;
      if (r_data) begin
        rx_rd <= rx_rd + {9'h000, a_nbytes};
      end
      // RL9 - free consumed frame memory.
      // RL10 - busy until freed.
      if (rel_busy) begin
        rx_head <= rx_rd;
        rel_busy <= 1'b0;
      end else if (rel_start) begin
        rel_busy <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Interrupts.
  // ---------------------------------------------------------------
  logic [15:0] int_stat;
  logic [15:0] int_mask;
  logic [15:0] int_set;

  always_comb begin
    int_set = 16'h0000;
    // RL4 - packet completion event.
    int_set[qcpr_pkg::INT_RX_FRAME] = stat_done;
    int_set[qcpr_pkg::INT_TX_DONE] = tx_done;
    int_set[qcpr_pkg::INT_RX_RELEASED] = rel_busy;
    int_set[qcpr_pkg::INT_RX_DROPPED] = rx_drop;
  end

  wire logic [15:0] int_clr = w_stat ? w_reg : 16'h0000;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      int_stat <= qcpr_pkg::INT_RESET;
      int_mask <= qcpr_pkg::INT_RESET;
      irq_o <= 1'b0;
    end else begin
      // A new event wins over a clear in the same cycle.
      int_stat <= (int_stat & ~int_clr) | int_set;
      if (w_mask) begin
        int_mask <= w_reg;
      end
      irq_o <= |(int_stat & int_mask);
    end
  end

  // ---------------------------------------------------------------
  // Read data.
  // ---------------------------------------------------------------
  logic [31:0] rd_mux;

  always_comb begin
    case (a_idx)
      qcpr_pkg::IDX_TX_ENQUEUE_COMMAND: rd_mux = {31'h0, tx_busy};
      qcpr_pkg::IDX_RX_RELEASE_COMMAND: rd_mux = {31'h0, rel_busy};
      qcpr_pkg::IDX_TX_FRAME_POINTER: rd_mux = {17'h0, tx_auto, 3'h0, tx_ptr};
      // RL1 - committed byte count.
      qcpr_pkg::IDX_RX_QUEUE_FILL_LEVEL: rd_mux = {19'h0, rx_fill};
      qcpr_pkg::IDX_QUEUE_DATA: rd_mux = {rd_lane[3], rd_lane[2], rd_lane[1], rd_lane[0]};
      qcpr_pkg::IDX_INT_STATUS: rd_mux = {16'h0, int_stat};
      qcpr_pkg::IDX_INT_MASK: rd_mux = {16'h0, int_mask};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      hrdata_o <= 32'h0000_0000;
      hresp_o <= 1'b0;
    end else begin
      hresp_o <= 1'b0;
      if (rd_take) begin
        hrdata_o <= rd_mux;
      end
    end
  end

endmodule
`default_nettype wire

// ### hdl/qcpr_pkg.sv
`default_nettype none
package qcpr_pkg;

  // ---------------------------------------------------------------
  // Register indices; the byte address is four times the index.
  // ---------------------------------------------------------------
  localparam logic [5:0] IDX_TX_ENQUEUE_COMMAND = 6'h00;
  localparam logic [5:0] IDX_RX_RELEASE_COMMAND = 6'h02;
  localparam logic [5:0] IDX_TX_FRAME_POINTER = 6'h04;
  localparam logic [5:0] IDX_RX_QUEUE_FILL_LEVEL = 6'h0A;
  localparam logic [5:0] IDX_QUEUE_DATA = 6'h10;
  localparam logic [5:0] IDX_INT_STATUS = 6'h11;
  localparam logic [5:0] IDX_INT_MASK = 6'h12;

  // ---------------------------------------------------------------
  // Field positions and widths.
  // ---------------------------------------------------------------
  localparam int ENQUEUE_FRAME_BIT = 0;
  localparam int RELEASE_FRAME_BIT = 0;
  localparam int TX_POINTER_AUTO_ADVANCE = 14;
  localparam int TX_PTR_W = 11;
  localparam int RX_PTR_W = 12;
  localparam int FILL_W = 13;
  localparam int REG_W = 16;

  // Interrupt status and mask bits share this layout.
  localparam int INT_TX_DONE = 0;
  localparam int INT_RX_RELEASED = 1;
  localparam int INT_RX_DROPPED = 2;
  localparam int INT_RX_FRAME = 13;

  // ---------------------------------------------------------------
  // Queue sizes and reset values.
  // ---------------------------------------------------------------
  localparam int TXQ_DEPTH = 2048;
  localparam int RXQ_DEPTH = 4096;
  localparam logic [12:0] RXQ_BYTES = 13'h1000;
  localparam logic [12:0] RX_STATUS_BYTES = 13'h0004;
  localparam logic [1:0] RX_STATUS_LAST = 2'h3;
  localparam logic [10:0] TX_PTR_RESET = 11'h000;
  localparam logic [15:0] INT_RESET = 16'h0000;

  // AHB encodings.
  localparam logic [2:0] HSIZE_BYTE = 3'h0;
  localparam logic [2:0] HSIZE_HALF = 3'h1;

endpackage
`default_nettype wire

// ### bench/qcpr_checker.sv
`timescale 1ns/1ps
`default_nettype none
module qcpr_checker (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_last_i,
  input wire logic rx_ready_o,
  input wire logic tx_valid_o,
  input wire logic [7:0] tx_data_o,
  input wire logic tx_last_o,
  input wire logic tx_ready_i,
  input wire logic irq_o
);
  // ----
  // Taken transfers.
  // ----
  wire logic rd_t = hsel_i && htrans_i[1] && hready_i && !hwrite_i;
  wire logic wr_t = hsel_i && htrans_i[1] && hready_i && hwrite_i;
  wire logic [5:0] idx = haddr_i[7:2];
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  property p_fill_rsv;
    rd_t && idx == qcpr_pkg::IDX_RX_QUEUE_FILL_LEVEL |=> hrdata_o[31:13] == 19'h0;
  endproperty
  a_fill_rsv: assert property (p_fill_rsv) else $error("fill upper bits set");
  property p_enq_rsv;
    rd_t && idx == qcpr_pkg::IDX_TX_ENQUEUE_COMMAND |=> hrdata_o[31:1] == 31'h0;
  endproperty
  a_enq_rsv: assert property (p_enq_rsv) else $error("enqueue upper bits set");
  property p_enq_busy;
    rd_t && idx == qcpr_pkg::IDX_TX_ENQUEUE_COMMAND && tx_valid_o && !tx_last_o |=> hrdata_o[0];
  endproperty
  a_enq_busy: assert property (p_enq_busy) else $error("enqueue bit low while sending");
  // A discarded frame ends with no status gap, so the gap is checked once it has begun.
  property p_rx_gap;
    rx_valid_i && rx_ready_o && rx_last_i ##1 !rx_ready_o |-> !rx_ready_o [*4] ##1 rx_ready_o;
  endproperty
  a_rx_gap: assert property (p_rx_gap) else $error("status gap wrong");
  property p_rx_stall;
    rx_ready_o ##1 !rx_ready_o |-> $past(rx_valid_i) && $past(rx_last_i);
  endproperty
  a_rx_stall: assert property (p_rx_stall) else $error("receive stalled mid frame");
  property p_wr_wait;
    wr_t |=> !hreadyout_o ##1 (hreadyout_o && !hresp_o);
  endproperty
  a_wr_wait: assert property (p_wr_wait) else $error("write wait state wrong");
  property p_rd_hold;
    !rd_t |=> $stable(hrdata_o);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_tx_hold;
    tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o) && $stable(tx_last_o);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx byte dropped");
  property p_tx_end;
    tx_valid_o && tx_ready_i && tx_last_o |=> !tx_valid_o;
  endproperty
  a_tx_end: assert property (p_tx_end) else $error("tx runs past last");
  property p_reset_idle;
    $fell(rst_i) |-> hreadyout_o && !tx_valid_o && !irq_o && hrdata_o == 32'h0;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("not idle after reset");
  c_tx_end: cover property (tx_valid_o && tx_ready_i && tx_last_o);
  c_rx_end: cover property (rx_valid_i && rx_ready_o && rx_last_i);
  c_irq: cover property ($rose(irq_o));
endmodule
bind qcpr_top qcpr_checker qcpr_checker_inst (.*);
`default_nettype wire

// ### bench/qcpr_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module qcpr_top_tb;
  // ----
  // Stimulus and checks.
  // ----
  localparam logic [7:0] A_ENQ = {qcpr_pkg::IDX_TX_ENQUEUE_COMMAND, 2'h0};
  localparam logic [7:0] A_REL = {qcpr_pkg::IDX_RX_RELEASE_COMMAND, 2'h0};
  localparam logic [7:0] A_PTR = {qcpr_pkg::IDX_TX_FRAME_POINTER, 2'h0};
  localparam logic [7:0] A_FILL = {qcpr_pkg::IDX_RX_QUEUE_FILL_LEVEL, 2'h0};
  localparam logic [7:0] A_DATA = {qcpr_pkg::IDX_QUEUE_DATA, 2'h0};
  localparam logic [7:0] A_STAT = {qcpr_pkg::IDX_INT_STATUS, 2'h0};
  localparam logic [7:0] A_MASK = {qcpr_pkg::IDX_INT_MASK, 2'h0};
  logic clk_sys_i = 1'h0;
  logic rst_i = 1'h1;
  logic hsel_i = 1'h0;
  logic hwrite_i = 1'h0;
  logic rx_valid_i = 1'h0;
  logic rx_last_i = 1'h0;
  logic tx_ready_i = 1'h0;
  logic [1:0] htrans_i = 2'h0;
  logic [2:0] hsize_i = 3'h2;
  logic [31:0] haddr_i = 32'h0;
  logic [31:0] hwdata_i = 32'h0;
  logic [7:0] rx_data_i = 8'h0;
  logic [31:0] hrdata_o;
  logic [31:0] rd;
  logic [7:0] tx_data_o;
  logic hready_i, hreadyout_o, hresp_o, rx_ready_o, tx_valid_o, tx_last_o, irq_o;
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;
  assign hready_i = hreadyout_o;
  qcpr_top qcpr_top_inst (.*);
  initial begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  // The whole run needs a little over four thousand cycles, most of them for the overfilled frame.
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("errors %0d checks %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, input logic [2:0] sz = 3'h2);
    hsel_i <= 1'h1;
    htrans_i <= 2'h2;
    haddr_i <= {24'h0, a};
    hwrite_i <= w;
    hsize_i <= sz;
    do @(posedge clk_sys_i); while (hready_i !== 1'h1);
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    do @(posedge clk_sys_i); while (hready_i !== 1'h1);
    rd = hrdata_o;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic send(input logic [7:0] d, input logic l);
    rx_valid_i <= 1'h1;
    rx_data_i <= d;
    rx_last_i <= l;
    do @(posedge clk_sys_i); while (rx_ready_o !== 1'h1);
  endtask
  task automatic wait_clear(input logic [7:0] a);
    int n = 0;
    do begin
      bus(1'h0, a, 32'h0);
      n++;
    end while (rd[0] !== 1'h0 && n < 50);
    chk(rd & 32'h1, 32'h0);
  endtask
  task automatic t_regs();
    rdc(A_PTR, 32'h0);
    rdc(A_ENQ, 32'h0);
    rdc(A_REL, 32'h0);
    rdc(A_FILL, 32'h0);
    rdc(8'h3C, 32'h0);
    bus(1'h1, A_PTR, 32'hFFFF);
    rdc(A_PTR, 32'h47FF);
    bus(1'h1, A_PTR, 32'h47FE);
    bus(1'h1, A_DATA, 32'h0, 3'h0);
    rdc(A_PTR, 32'h47FF);
    bus(1'h1, A_DATA, 32'h0, 3'h1);
    rdc(A_PTR, 32'h4001);
    bus(1'h1, A_PTR, 32'h0010);
    bus(1'h1, A_DATA, 32'h0);
    rdc(A_PTR, 32'h0010);
  endtask
  task automatic t_tx();
    bus(1'h1, A_PTR, 32'h4000);
    bus(1'h1, A_DATA, 32'h44332211);
    bus(1'h1, A_DATA, 32'h55, 3'h0);
    rdc(A_PTR, 32'h4005);
    bus(1'h1, A_ENQ, 32'h1);
    rdc(A_ENQ, 32'h1);
    for (int i = 0; i < 5; i++) begin
      do @(posedge clk_sys_i); while (tx_valid_o !== 1'h1);
      chk({23'h0, tx_last_o, tx_data_o}, {23'h0, i == 4, 8'(8'h11 * (i + 1))});
      tx_ready_i <= 1'h1;
      @(posedge clk_sys_i);
      tx_ready_i <= 1'h0;
    end
    repeat (2) @(posedge clk_sys_i);
    rdc(A_ENQ, 32'h0);
    wait_clear(A_ENQ);
    bus(1'h0, A_PTR, 32'h0);
    chk(rd & 32'h7FF, 32'h5);
    rdc(A_STAT, 32'h1);
    bus(1'h1, A_STAT, 32'h1);
  endtask
  task automatic t_rx();
    bus(1'h1, A_MASK, 32'h2000);
    for (int i = 0; i < 3; i++) send(8'(8'hA0 + i), 1'h0);
    rx_valid_i <= 1'h0;
    rdc(A_FILL, 32'h0);
    for (int i = 3; i < 6; i++) send(8'(8'hA0 + i), i == 5);
    rx_valid_i <= 1'h0;
    repeat (6) @(posedge clk_sys_i);
    rdc(A_FILL, 32'hA);
    chk(irq_o, 32'h1);
    bus(1'h1, A_MASK, 32'h0);
    repeat (2) @(posedge clk_sys_i);
    chk(irq_o, 32'h0);
    bus(1'h1, A_MASK, 32'h2000);
    repeat (2) @(posedge clk_sys_i);
    chk(irq_o, 32'h1);
    bus(1'h1, A_STAT, 32'h2000);
    repeat (2) @(posedge clk_sys_i);
    chk(irq_o, 32'h0);
    rdc(A_DATA, 32'hA3A2A1A0);
    bus(1'h1, A_REL, 32'h1);
    wait_clear(A_REL);
    rdc(A_REL, 32'h0);
    rdc(A_FILL, 32'h6);
  endtask
  task automatic t_drop();
    for (int i = 0; i < 4090; i++) send(8'(i), i == 4089);
    rx_valid_i <= 1'h0;
    repeat (6) @(posedge clk_sys_i);
    rdc(A_FILL, 32'h6);
    rdc(A_STAT, 32'h6);
    for (int i = 0; i < 2; i++) send(8'hC0, i == 1);
    rx_valid_i <= 1'h0;
    repeat (6) @(posedge clk_sys_i);
    rdc(A_FILL, 32'hC);
  endtask
  initial begin
    repeat (10) @(posedge clk_sys_i);
    rst_i <= 1'h0;
    @(posedge clk_sys_i);
    t_regs();
    t_tx();
    t_rx();
    t_drop();
    give_verdict();
  end
endmodule
`default_nettype wire
